// ==== design/occ_top.sv ====
// Purpose: Oscillator source selection, clock divisors and lock flags
// Assumes: Oscillator, loop and monitor status arrive from other clocks
// Notes:   Frequencies are reported as ratios; no clock is generated here
//
// How it works
// - Auxiliary loop multiplies its reference by sixteen
// - Fine resolution only with auxiliary loop source
// - Read-only current source field in bits 14-12
// - Next source field, power-on value from straps
// - Switch request bit starts change, reads 0 after
// - Freeze bit plus monitor config locks settings
// - Bit 6 freezes pin mapping, resets 0
// - Bit 5 shows loop locked, only while a loop source is selected
// - Monitor sets fail flag; writing 1 traps
// - Control register writes need unlock sequence
// - Interrupt clears reduction enable when recover set
// - Reduction field selects divide 1 to 128
// - Reduction enable applies ratio, else 1:1
// - Reduction field writes ignored while enabled
// - Enable cannot be set while field is zero
// - Fast RC postscaler divides 1 to 256
// - VCO output divider 2, 4, 8; 10 reserved
// - Phase input divider is field plus two
// - Nine-bit feedback field sets loop multiplier
// - Effective multiplier is field plus two
//
// Register access over AHB-Lite and the address map were decided locally.
module occ_top (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [2:0]  strap_src,
	input  wire logic        strap_fail_mon,
	input  wire logic        osc_ready,
	input  wire logic        loop_locked,
	input  wire logic        clock_fail,
	input  wire logic        irq_any,
	input  wire logic        aux_from_loop,
	output logic      [2:0]  source_sel,
	output logic             switch_busy,
	output logic             fail_trap,
	output logic             pin_map_lock,
	output logic             cfg_locked,
	output logic             aux_vco_src,
	output logic      [12:0] pwm_res_ps,
	output occ_pkg::occ_ratio_t ratios
);
	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [3:0] sync1_ff;
	logic [3:0] sync2_ff;
	logic       osc_rdy_s;
	logic       lock_s;
	logic       fail_s;
	logic       irq_s;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync1_ff <= 4'h0;
			sync2_ff <= 4'h0;
		end
		else
		begin
			sync1_ff <= {irq_any, clock_fail, loop_locked, osc_ready};
			sync2_ff <= sync1_ff;
		end
	end
	assign {irq_s, fail_s, lock_s, osc_rdy_s} = sync2_ff;

	// ----------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ----------------------------------------------------------------
	logic       wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic       wr_ev;
	assign wr_ev = wr_pend_ff;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend_ff <= hsel && htrans[1] && hwrite;
			wr_addr_ff <= haddr[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Unlock sequence: key 1 then key 2 opens a single control write
	// ----------------------------------------------------------------
	logic [1:0] unlk_ff;
	logic       ctrl_wr;
	assign ctrl_wr = wr_ev && wr_addr_ff == occ_pkg::OSC_CTRL_OFS &&
		unlk_ff == 2'h2;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			unlk_ff <= 2'h0;
		else if (wr_ev && wr_addr_ff == occ_pkg::UNLOCK_OFS)
		begin
			if (hwdata[15:0] == occ_pkg::UNLOCK_KEY1)
				unlk_ff <= 2'h1;
			else if (hwdata[15:0] == occ_pkg::UNLOCK_KEY2 && unlk_ff == 2'h1)
				unlk_ff <= 2'h2;
			else
				unlk_ff <= 2'h0;
		end
		else if (wr_ev)
			unlk_ff <= 2'h0;
	end

	// ----------------------------------------------------------------
	// Configuration lock
	// ----------------------------------------------------------------
	logic cfg_frz_ff;
	logic pin_frz_ff;
	logic mon_cfg_ff;
	logic locked;
	// Strap caught after release, never under the asynchronous reset
	logic strap_done_ff;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			strap_done_ff <= 1'b0;
			mon_cfg_ff    <= 1'b0;
		end
		else if (!strap_done_ff)
		begin
			strap_done_ff <= 1'b1;
			mon_cfg_ff    <= strap_fail_mon;
		end
	end
	assign locked = cfg_frz_ff && mon_cfg_ff;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cfg_frz_ff <= 1'b0;
			pin_frz_ff <= 1'b0;
		end
		else if (ctrl_wr)
		begin
			cfg_frz_ff <= hwdata[occ_pkg::CFG_FRZ_BIT];
			pin_frz_ff <= hwdata[occ_pkg::PIN_FRZ_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Source switching
	// ----------------------------------------------------------------
	occ_pkg::occ_sw_state_t sw_state_ff;
	logic [2:0] cur_src_ff;
	logic [2:0] nxt_src_ff;
	logic       sw_req_ff;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			nxt_src_ff <= occ_pkg::SRC_FRC;
		else if (!strap_done_ff)
			nxt_src_ff <= strap_src;
		else if (ctrl_wr && !locked)
			nxt_src_ff <= hwdata[occ_pkg::NXT_SRC_LSB +: 3];
	end
	// Request is ignored for the reserved code so the switch cannot hang
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sw_state_ff <= occ_pkg::OCC_IDLE;
			sw_req_ff   <= 1'b0;
			cur_src_ff  <= occ_pkg::SRC_FRC;
		end
		else if (!strap_done_ff)
			cur_src_ff <= strap_src;
		else
		begin
			unique case (sw_state_ff)
				occ_pkg::OCC_IDLE:
					if (ctrl_wr && !locked && hwdata[occ_pkg::SWITCH_BIT] &&
						hwdata[occ_pkg::NXT_SRC_LSB +: 3] != occ_pkg::SRC_RSVD)
					begin
						sw_req_ff   <= 1'b1;
						sw_state_ff <= occ_pkg::OCC_SWITCH;
					end
				occ_pkg::OCC_SWITCH:
					if (osc_rdy_s)
					begin
						cur_src_ff  <= nxt_src_ff;
						sw_state_ff <= occ_pkg::OCC_DONE;
					end
				occ_pkg::OCC_DONE:
				begin
					sw_req_ff   <= 1'b0;
					sw_state_ff <= occ_pkg::OCC_IDLE;
				end
				default: sw_state_ff <= occ_pkg::OCC_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Clock fail flag; set wins over clear
	// ----------------------------------------------------------------
	logic fail_ff;
	logic fail_trap_ff;
	logic sw_fail_set;
	assign sw_fail_set = ctrl_wr && hwdata[occ_pkg::FAIL_BIT];
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			fail_ff      <= 1'b0;
			fail_trap_ff <= 1'b0;
		end
		else
		begin
			if (fail_s || sw_fail_set)
				fail_ff <= 1'b1;
			else if (ctrl_wr)
				fail_ff <= 1'b0;
			fail_trap_ff <= fail_s || sw_fail_set;
		end
	end

	// ----------------------------------------------------------------
	// Clock divisor and feedback registers
	// ----------------------------------------------------------------
	logic       roi_ff;
	logic [2:0] red_ff;
	logic       red_en_ff;
	logic [2:0] frc_ps_ff;
	logic [1:0] vco_div_ff;
	logic [4:0] phase_ff;
	logic [8:0] fbd_ff;
	logic       div_wr;
	logic [2:0] nxt_red;
	assign div_wr  = wr_ev && wr_addr_ff == occ_pkg::CLK_DIV_OFS;
	assign nxt_red = red_en_ff ? red_ff : hwdata[occ_pkg::RED_LSB +: 3];
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			roi_ff     <= 1'b0;
			red_ff     <= occ_pkg::RED_RST;
			red_en_ff  <= 1'b0;
			frc_ps_ff  <= occ_pkg::FRC_PS_RST;
			vco_div_ff <= occ_pkg::VCO_DIV_RST;
			phase_ff   <= occ_pkg::PHASE_DIV_RST;
		end
		else
		begin
			if (div_wr)
			begin
				roi_ff <= hwdata[occ_pkg::ROI_BIT];
				red_ff <= nxt_red;
				if (!locked)
				begin
					frc_ps_ff <= hwdata[occ_pkg::FRC_PS_LSB +: 3];
					// Reserved divider code keeps the old setting
					if (hwdata[occ_pkg::VCO_DIV_LSB +: 2] !=
						occ_pkg::VCO_DIV_RSVD)
						vco_div_ff <= hwdata[occ_pkg::VCO_DIV_LSB +: 2];
					phase_ff <= hwdata[occ_pkg::PHASE_DIV_LSB +: 5];
				end
			end
			// Interrupt recovery outranks a same-cycle enable write
			if (irq_s && roi_ff)
				red_en_ff <= 1'b0;
			else if (div_wr)
				red_en_ff <= hwdata[occ_pkg::RED_EN_BIT] &&
					nxt_red != occ_pkg::RED_OFF;
		end
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			fbd_ff <= occ_pkg::FBD_RST;
		else if (wr_ev && wr_addr_ff == occ_pkg::PLL_FBD_OFS && !locked)
			fbd_ff <= hwdata[8:0];
	end

	// ----------------------------------------------------------------
	// Readback, unimplemented bits zero
	// ----------------------------------------------------------------
	logic [15:0] osc_rd;
	logic [15:0] div_rd;
	logic        loop_ok;
	assign loop_ok = lock_s &&
		(cur_src_ff == occ_pkg::SRC_FRC_PLL ||
		 cur_src_ff == occ_pkg::SRC_PRI_PLL);
	assign osc_rd = {1'b0, cur_src_ff, 1'b0, nxt_src_ff, cfg_frz_ff,
		pin_frz_ff, loop_ok, 1'b0, fail_ff, 2'b00, sw_req_ff};
	assign div_rd = {roi_ff, red_ff, red_en_ff, frc_ps_ff, vco_div_ff, 1'b0,
		phase_ff};
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (hsel && hready && htrans[1] && !hwrite)
		begin
			unique case (haddr[7:0])
				occ_pkg::OSC_CTRL_OFS: hrdata <= {16'h0000, osc_rd};
				occ_pkg::CLK_DIV_OFS:  hrdata <= {16'h0000, div_rd};
				occ_pkg::PLL_FBD_OFS:  hrdata <= {23'h00_0000, fbd_ff};
				occ_pkg::UNLOCK_OFS:   hrdata <= {30'h0000_0000, unlk_ff};
				default:               hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Clock control outputs
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout    <= 1'b1;
			hresp        <= 1'b0;
			source_sel   <= occ_pkg::SRC_FRC;
			switch_busy  <= 1'b0;
			fail_trap    <= 1'b0;
			pin_map_lock <= 1'b0;
			cfg_locked   <= 1'b0;
			aux_vco_src  <= 1'b0;
			pwm_res_ps   <= occ_pkg::RES_COARSE_PS;
			ratios       <= '0;
		end
		else
		begin
			hreadyout    <= 1'b1;
			hresp        <= 1'b0;
			source_sel   <= cur_src_ff;
			switch_busy  <= sw_req_ff;
			fail_trap    <= fail_trap_ff;
			pin_map_lock <= pin_frz_ff;
			cfg_locked   <= locked;
			aux_vco_src  <= !aux_from_loop;
			// Fine step needs the 16x loop; any other source is coarse
			pwm_res_ps   <= aux_from_loop ? occ_pkg::RES_FINE_PS :
				occ_pkg::RES_COARSE_PS;
			ratios.feedback_mult <= {1'b0, fbd_ff} + 10'h002;
			ratios.phase_div     <= {1'b0, phase_ff} + 6'h02;
			ratios.vco_div       <= vco_div_ff[1] ? 4'h8 :
				4'h2 << vco_div_ff[0];
			ratios.frc_div       <= (frc_ps_ff == 3'h7) ? 9'h100 :
				9'h001 << frc_ps_ff;
			ratios.reduce_div    <= red_en_ff ? 8'h01 << red_ff :
				8'h01;
		end
	end
endmodule // occ_top

// ==== design/occ_pkg.sv ====
// Purpose: Shared constants and types for the oscillator clock control block
// Assumes: AHB-Lite register access, 32-bit data, one word per register
// Notes:   Register offsets are byte addresses
package occ_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OSC_CTRL_OFS  = 8'h00;
	localparam logic [7:0] CLK_DIV_OFS   = 8'h04;
	localparam logic [7:0] PLL_FBD_OFS   = 8'h08;
	localparam logic [7:0] UNLOCK_OFS    = 8'h0C;
	localparam logic [7:0] EVENT_OFS     = 8'h10;

	// Unlock key pair, written in this order to the unlock register
	localparam logic [15:0] UNLOCK_KEY1  = 16'h0057;
	localparam logic [15:0] UNLOCK_KEY2  = 16'h00AA;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CUR_SRC_LSB   = 12;
	localparam int NXT_SRC_LSB   = 8;
	localparam int CFG_FRZ_BIT   = 7;
	localparam int PIN_FRZ_BIT   = 6;
	localparam int LOOP_LCK_BIT  = 5;
	localparam int FAIL_BIT      = 3;
	localparam int SWITCH_BIT    = 0;
	localparam int ROI_BIT       = 15;
	localparam int RED_LSB       = 12;
	localparam int RED_EN_BIT    = 11;
	localparam int FRC_PS_LSB    = 8;
	localparam int VCO_DIV_LSB   = 6;
	localparam int PHASE_DIV_LSB = 0;

	// ----------------------------------------------------------------
	// Reset values and fixed factors
	// ----------------------------------------------------------------
	localparam logic [2:0] RED_RST       = 3'h3;
	localparam logic [2:0] FRC_PS_RST    = 3'h0;
	localparam logic [1:0] VCO_DIV_RST   = 2'h1;
	localparam logic [4:0] PHASE_DIV_RST = 5'h00;
	localparam logic [8:0] FBD_RST       = 9'h030;
	localparam logic [4:0] AUX_MULT      = 5'h10;
	localparam logic [2:0] RED_OFF       = 3'h0;
	localparam logic [1:0] VCO_DIV_RSVD  = 2'h2;
	localparam logic [2:0] SRC_RSVD      = 3'h4;
	localparam logic [2:0] SRC_FRC       = 3'h0;
	localparam logic [2:0] SRC_FRC_PLL   = 3'h1;
	localparam logic [2:0] SRC_PRI_PLL   = 3'h3;
	localparam logic [12:0] RES_FINE_PS   = 13'h0410;
	localparam logic [12:0] RES_COARSE_PS = 13'h1f40;

	// Resolution in picoseconds: 1040 ps or 8000 ps
	typedef struct packed {
		// Field plus two reaches 513, one bit wider than the field
		logic [9:0] feedback_mult;
		logic [5:0] phase_div;
		logic [3:0] vco_div;
		logic [8:0] frc_div;
		logic [7:0] reduce_div;
	} occ_ratio_t;

	typedef enum logic [2:0] {
		OCC_IDLE   = 3'b001,
		OCC_SWITCH = 3'b010,
		OCC_DONE   = 3'b100
	} occ_sw_state_t;

endpackage : occ_pkg

// ==== tb/occ_props.sv ====
// Purpose: Port checker for occ_top, bound into the design
// Assumes: One hclk domain, hresetn asynchronous active low
// Notes:   Ratio checks wait two edges after reset for the registered ratios to load
module occ_props (
	input wire logic                hclk,
	input wire logic                hresetn,
	input wire logic                hreadyout,
	input wire logic                hresp,
	input wire logic                aux_from_loop,
	input wire logic                aux_vco_src,
	input wire logic [12:0]         pwm_res_ps,
	input wire logic [2:0]          source_sel,
	input wire logic                switch_busy,
	input wire occ_pkg::occ_ratio_t ratios
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	AST_RES_FINE: assert property (aux_from_loop |=>
		pwm_res_ps == occ_pkg::RES_FINE_PS) else $error("fine res wrong");
	AST_RES_COARSE: assert property (!aux_from_loop |=>
		pwm_res_ps == occ_pkg::RES_COARSE_PS) else $error("coarse res wrong");
	AST_AUX_SRC: assert property (1'b1 |=>
		aux_vco_src == !$past(aux_from_loop)) else $error("aux source wrong");
	AST_PHASE_RANGE: assert property ($past(hresetn, 2) |->
		ratios.phase_div inside {[6'h02:6'h21]}) else $error("phase div range");
	AST_VCO_DIV: assert property ($past(hresetn, 2) |->
		ratios.vco_div inside {4'h2, 4'h4, 4'h8}) else $error("vco div code");
	AST_REDUCE_POW2: assert property ($past(hresetn, 2) |->
		$onehot(ratios.reduce_div)) else $error("reduce div not power of two");
	AST_FRC_POW2: assert property ($past(hresetn, 2) |->
		$onehot(ratios.frc_div) && ratios.frc_div != 9'h080)
		else $error("frc div not allowed");
	AST_SRC_ON_SWITCH: assert property ($past(hresetn, 3) &&
		$changed(source_sel) |-> switch_busy) else $error("source moved idle");
	AST_BUSY_FALL: assert property ($fell(switch_busy) |->
		$stable(source_sel)) else $error("request cleared before source");

	// Main scenarios reached
	COV_SWITCH: cover property ($fell(switch_busy));
	COV_AUX: cover property (aux_from_loop ##1 !aux_from_loop);
	COV_REDUCE: cover property (ratios.reduce_div != 8'h01);
endmodule // occ_props

bind occ_top occ_props u_occ_props (.hclk, .hresetn, .hreadyout, .hresp,
	.aux_from_loop, .aux_vco_src, .pwm_res_ps, .source_sel, .switch_busy,
	.ratios);

// ==== tb/occ_top_tb_top.sv ====
// Purpose: Self-checking bench for occ_top over AHB-Lite
// Assumes: Zero-wait slave, but the master still waits on hready
// Notes:   Divisor expectations are tracked in dv_m and fb_m
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin \
	miscompares++; $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module occ_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, osc_ready = 0;
	logic        strap_fail_mon = 0, loop_locked = 1, clock_fail = 0;
	logic        irq_any = 0, aux_from_loop = 0, hreadyout, hresp, fail_trap;
	logic        switch_busy, pin_map_lock, cfg_locked, aux_vco_src;
	logic [2:0]  hsize = 3'h2, strap_src = 3'h2, source_sel, cur;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [12:0] pwm_res_ps;
	logic [15:0] dv_m, v;
	logic [8:0]  fb_m;
	logic [2:0]  seq [9] = '{5, 6, 7, 0, 1, 0, 3, 0, 2};
	occ_pkg::occ_ratio_t ratios;
	int miscompares = 0, tests_run = 0, cycles = 0, traps = 0, t0, n;
	int seed = 32'h0bab_f965;

	occ_top u_occ_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.strap_src, .strap_fail_mon, .osc_ready, .loop_locked, .clock_fail,
		.irq_any, .aux_from_loop, .source_sel, .switch_busy, .fail_trap,
		.pin_map_lock, .cfg_locked, .aux_vco_src, .pwm_res_ps, .ratios);

	always #2.5 hclk = ~hclk;

	// Aux source toggles at random so both resolutions are exercised
	always @(posedge hclk)
	begin
		// Bench plays software that keeps the aux clock set up legally
		aux_from_loop <= 1'($random(seed));
		cycles++;
		if (fail_trap === 1'b1)
			traps++;
		if (cycles == 30000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr  <= 32'(a);
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// Key pair, then the single control write it unlocks
	task automatic ul(input logic [31:0] d);
		ahb(1, occ_pkg::UNLOCK_OFS, 32'(occ_pkg::UNLOCK_KEY1));
		ahb(1, occ_pkg::UNLOCK_OFS, 32'(occ_pkg::UNLOCK_KEY2));
		ahb(1, occ_pkg::OSC_CTRL_OFS, d);
	endtask

	function automatic logic [31:0] ctl(logic [2:0] c, logic [2:0] x,
		logic [7:0] lo);
		ctl = {17'h0_0000, c, 1'b0, x, lo | ((c == 1 || c == 3) ? 8'h20 : 8'h00)};
	endfunction

	function automatic occ_pkg::occ_ratio_t exp_r(logic [8:0] fb,
		logic [15:0] dv);
		exp_r.feedback_mult = 10'(fb) + 10'h002;
		exp_r.phase_div     = 6'(dv[4:0]) + 6'h02;
		exp_r.vco_div       = dv[7] ? 4'h8 : (dv[6] ? 4'h4 : 4'h2);
		exp_r.frc_div = (dv[10:8] == 3'h7) ? 9'h100 : 9'h001 << dv[10:8];
		exp_r.reduce_div    = dv[11] ? 8'h01 << dv[14:12] : 8'h01;
	endfunction

	task automatic wr_div(input logic [15:0] w);
		ahb(1, occ_pkg::CLK_DIV_OFS, {16'hffff, w});
		if (dv_m[11])
			w[14:12] = dv_m[14:12];
		if (w[14:12] == 3'h0)
			w[11] = 1'b0;
		if (w[7:6] == 2'h2)
			w[7:6] = dv_m[7:6];
		dv_m = w & 16'hffdf;
	endtask

	task automatic chk_div();
		ahb(0, occ_pkg::CLK_DIV_OFS, 0);
		`CHK("divisor", {16'h0000, dv_m}, rd)
		`CHK("ratios", exp_r(fb_m, dv_m), ratios)
	endtask

	task automatic do_reset(input logic mon, input logic [2:0] s);
		hresetn        <= 1'b0;
		strap_fail_mon <= mon;
		strap_src      <= s;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		fb_m = 9'h030;
		dv_m = 16'h3040;
		cur  = s;
		ahb(0, occ_pkg::OSC_CTRL_OFS, 0);
		`CHK("ctrl rst", ctl(s, s, 8'h00), rd)
		chk_div();
		ahb(0, occ_pkg::PLL_FBD_OFS, 0);
		`CHK("fbd rst", 32'h0000_0030, rd)
		ahb(0, occ_pkg::EVENT_OFS, 0);
		`CHK("unmapped", 32'h0000_0000, rd)
	endtask

	initial
	begin
		do_reset(1'b0, 3'h2);
		ahb(1, occ_pkg::OSC_CTRL_OFS, 32'h0000_01c0);
		ahb(0, occ_pkg::OSC_CTRL_OFS, 0);
		`CHK("locked ctrl", ctl(3'h2, 3'h2, 8'h00), rd)
		ul(32'hffff_8040);
		ahb(0, occ_pkg::OSC_CTRL_OFS, 0);
		`CHK("ctrl wr", ctl(3'h2, 3'h0, 8'h40), rd)
		`CHK("pin lock", 1'b1, pin_map_lock)
		foreach (seq[i])
		begin
			ul(32'h0000_0041 | (32'(seq[i]) << 8));
			repeat (2 + ($random(seed) & 7)) @(posedge hclk);
			`CHK("busy", 1'b1, switch_busy)
			osc_ready <= 1'b1;
			n = 0;
			while (switch_busy !== 1'b0 && n < 50)
			begin
				@(posedge hclk);
				n++;
			end
			osc_ready <= 1'b0;
			cur = seq[i];
			`CHK("source", cur, source_sel)
			ahb(0, occ_pkg::OSC_CTRL_OFS, 0);
			`CHK("ctrl sw", ctl(cur, cur, 8'h40), rd)
		end
		ul(32'h0000_0441);
		repeat (4) @(posedge hclk);
		`CHK("rsvd busy", 1'b0, switch_busy)
		`CHK("rsvd src", cur, source_sel)
		t0 = traps;
		clock_fail <= 1'b1;
		repeat (4) @(posedge hclk);
		clock_fail <= 1'b0;
		ahb(0, occ_pkg::OSC_CTRL_OFS, 0);
		`CHK("hw fail", 1'b1, rd[3])
		`CHK("hw trap", 1'b1, traps > t0)
		ul(32'h0000_0040);
		ahb(0, occ_pkg::OSC_CTRL_OFS, 0);
		`CHK("fail clr", 1'b0, rd[3])
		t0 = traps;
		ul(32'h0000_0048);
		repeat (3) @(posedge hclk);
		`CHK("sw trap", 1'b1, traps > t0)
		for (int i = 0; i < 6; i++)
		begin
			v = 16'($random(seed)) & 16'h77df;
			if (i == 0)
				v[14:12] = 3'h0;
			wr_div(v);
			chk_div();
			v[14:12] = dv_m[14:12];
			v[11] = 1'b1;
			wr_div(v);
			chk_div();
			v[14:12] = ~v[14:12];
			v[11] = dv_m[11];
			wr_div(v);
			chk_div();
		end
		wr_div(16'h3040);
		for (int r = 1; r >= 0; r--)
		begin
			wr_div(16'h3840 | (16'(r) << 15));
			irq_any <= 1'b1;
			repeat (4) @(posedge hclk);
			irq_any <= 1'b0;
			repeat (4) @(posedge hclk);
			dv_m[11] = (r == 0);
			chk_div();
		end
		ul(32'h0000_00c0);
		repeat (3) @(posedge hclk);
		`CHK("cfg open", 1'b0, cfg_locked)
		repeat (4)
		begin
			fb_m = 9'($random(seed));
			ahb(1, occ_pkg::PLL_FBD_OFS, 32'hffff_fe00 | 32'(fb_m));
			ahb(0, occ_pkg::PLL_FBD_OFS, 0);
			`CHK("fbd", 32'(fb_m), rd)
			`CHK("mult", 10'(fb_m) + 10'h002, ratios.feedback_mult)
		end
		do_reset(1'b1, 3'h5);
		ul(32'h0000_0080);
		repeat (3) @(posedge hclk);
		`CHK("cfg lock", 1'b1, cfg_locked)
		ahb(1, occ_pkg::PLL_FBD_OFS, 32'h0000_01ff);
		ahb(0, occ_pkg::PLL_FBD_OFS, 0);
		`CHK("fbd lock", 32'h0000_0030, rd)
		tally_and_finish();
	end
endmodule // occ_top_tb_top
